// ---- jtp_pkg.sv ----
/*
  Constants, state encoding and the controller step function shared by
  the test access port and its stream buffer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package jtp_pkg;

  // Widths and depths
  localparam int JTP_SYNC_N = 3;
  localparam int JTP_IR_W   = 4;
  localparam int JTP_DR_W   = 32;
  localparam int JTP_WORD_W = 8;
  localparam int JTP_CNT_W  = 3;
  localparam int JTP_FIFO_D = 4;

  // Instruction codes
  localparam logic [JTP_IR_W-1:0] JTP_IR_BYPASS = 4'hF;
  localparam logic [JTP_IR_W-1:0] JTP_IR_IDCODE = 4'h1;
  localparam logic [JTP_IR_W-1:0] JTP_IR_STREAM = 4'h8;
  localparam logic [JTP_IR_W-1:0] JTP_IR_RST    = JTP_IR_IDCODE;
  // Fixed pattern loaded on instruction capture
  localparam logic [JTP_IR_W-1:0] JTP_IR_CAP    = 4'h1;

  // Identification value: arbitrary, bit 0 set as the scan format needs
  localparam logic [JTP_DR_W-1:0] JTP_IDCODE    = 32'h0A5A_0001;

  localparam logic [JTP_CNT_W-1:0] JTP_CNT_LAST = 3'h7;

  // Controller states, Gray coded along the usual scan path
  typedef enum logic [3:0] {
    JTP_TLR    = 4'h0,
    JTP_RTI    = 4'h1,
    JTP_SEL_DR = 4'h3,
    JTP_CAP_DR = 4'h2,
    JTP_SH_DR  = 4'h6,
    JTP_EX1_DR = 4'h7,
    JTP_PA_DR  = 4'h5,
    JTP_EX2_DR = 4'h4,
    JTP_UPD_DR = 4'hC,
    JTP_SEL_IR = 4'hD,
    JTP_CAP_IR = 4'hF,
    JTP_SH_IR  = 4'hE,
    JTP_EX1_IR = 4'hA,
    JTP_PA_IR  = 4'hB,
    JTP_EX2_IR = 4'h9,
    JTP_UPD_IR = 4'h8
  } jtp_tap_t;

  // One controller step on a test clock rising edge
  function automatic jtp_tap_t jtp_tap_next(input jtp_tap_t s,
                                            input logic     tms);
    jtp_tap_t n;
    n = s;
    unique case (s)
      JTP_TLR:    n = tms ? JTP_TLR    : JTP_RTI;
      JTP_RTI:    n = tms ? JTP_SEL_DR : JTP_RTI;
      JTP_SEL_DR: n = tms ? JTP_SEL_IR : JTP_CAP_DR;
      JTP_CAP_DR: n = tms ? JTP_EX1_DR : JTP_SH_DR;
      JTP_SH_DR:  n = tms ? JTP_EX1_DR : JTP_SH_DR;
      JTP_EX1_DR: n = tms ? JTP_UPD_DR : JTP_PA_DR;
      JTP_PA_DR:  n = tms ? JTP_EX2_DR : JTP_PA_DR;
      JTP_EX2_DR: n = tms ? JTP_UPD_DR : JTP_SH_DR;
      JTP_UPD_DR: n = tms ? JTP_SEL_DR : JTP_RTI;
      JTP_SEL_IR: n = tms ? JTP_TLR    : JTP_CAP_IR;
      JTP_CAP_IR: n = tms ? JTP_EX1_IR : JTP_SH_IR;
      JTP_SH_IR:  n = tms ? JTP_EX1_IR : JTP_SH_IR;
      JTP_EX1_IR: n = tms ? JTP_UPD_IR : JTP_PA_IR;
      JTP_PA_IR:  n = tms ? JTP_EX2_IR : JTP_PA_IR;
      JTP_EX2_IR: n = tms ? JTP_UPD_IR : JTP_SH_IR;
      JTP_UPD_IR: n = tms ? JTP_SEL_DR : JTP_RTI;
    endcase
    return n;
  endfunction : jtp_tap_next

endpackage : jtp_pkg

// ---- jtp_fifo.sv ----
/*
  Shift-style FIFO with valid/ready on both sides; the head entry and
  all flags are flip-flops.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module jtp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  import jtp_pkg::*;

  typedef struct packed {
    logic [D-1:0]        vld;
    logic [D-1:0][W-1:0] mem;
  } jtp_fifo_st_t;

  jtp_fifo_st_t st;
  jtp_fifo_st_t next_st;
  logic         done;

  always_comb begin
    next_st = st;
    done    = 1'b0;
    // Pop shifts every entry one place toward the head
    if (st.vld[0] && out_ready_i) begin
      for (int i = 0; i < D - 1; i++) begin
        next_st.mem[i] = st.mem[i+1];
        next_st.vld[i] = st.vld[i+1];
      end
      next_st.vld[D-1] = 1'b0;
    end
    // Push lands in the first free slot after the pop
    if (in_valid_i && !st.vld[D-1]) begin
      for (int i = 0; i < D; i++) begin
        if (!done && !next_st.vld[i]) begin
          next_st.mem[i] = in_data_i;
          next_st.vld[i] = 1'b1;
          done           = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_o  = ~st.vld[D-1];
  assign out_valid_o = st.vld[0];
  assign out_data_o  = st.mem[0];

endmodule : jtp_fifo

// ---- jtp_tap.sv ----
/*
  Boundary-scan test access port run from the system clock. The test
  clock, mode select, data input and test reset are sampled, the test clock
  edges found, and a sixteen-state controller with instruction, bypass,
  identification and a byte stream register is stepped on them. Bytes
  shifted in under the stream instruction leave through a small FIFO.
  Assumes the test clock is well below a quarter of ref_clk_i and that
  the clock-fail interrupt and its select bit come from logic on
  ref_clk_i. The pad resolves the output from tdo_oe_n_o.
*/
`timescale 1ns/100ps
module jtp_tap (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          srst_i,
  // Test port pins
  input  wire logic                          tck_i,
  input  wire logic                          tms_i,
  input  wire logic                          tdi_i,
  input  wire logic                          trst_n_i,
  output logic                               tdo_o,
  output logic                               tdo_oe_n_o,
  // Clock-fail flag reuse of the data output
  input  wire logic                          clk_fail_irq_i,
  input  wire logic                          clock_fail_flag_to_test_output_select_i,
  // Stream of shifted-in bytes
  output logic [jtp_pkg::JTP_WORD_W-1:0]     stream_data_o,
  output logic                               stream_valid_o,
  input  wire logic                          stream_ready_i,
  output logic                               stream_overflow_o
);
  import jtp_pkg::*;

  typedef struct packed {
    logic [JTP_SYNC_N-1:0] tck_s;
    logic [JTP_SYNC_N-1:0] tms_s;
    logic [JTP_SYNC_N-1:0] tdi_s;
    logic [JTP_SYNC_N-1:0] trst_s;
    logic                  tck_lvl;
    logic                  trst_lvl;
    jtp_tap_t              tap;
    logic [JTP_IR_W-1:0]   ir_sh;
    logic [JTP_IR_W-1:0]   ir;
    logic [JTP_DR_W-1:0]   dr_sh;
    logic                  byp;
    logic [JTP_WORD_W-1:0] word;
    logic [JTP_CNT_W-1:0]  bit_cnt;
    logic                  pend;
    logic [JTP_WORD_W-1:0] pend_word;
    logic                  ovf;
    logic                  tdo;
    logic                  tdo_oe_n;
  } jtp_st_t;

  jtp_st_t  st;
  jtp_st_t  next_st;
  logic     tck_rise;
  logic     tck_fall;
  logic     tms_smp;
  logic     tdi_smp;
  logic     scanning;
  logic     fifo_in_ready;
  jtp_tap_t exp_tap;

  assign tms_smp  = st.tms_s[2];
  assign tdi_smp  = st.tdi_s[2];
  // An edge counts once the second and third stages agree
  assign tck_rise = st.tck_s[1] & st.tck_s[2] & ~st.tck_lvl;
  assign tck_fall = ~st.tck_s[1] & ~st.tck_s[2] & st.tck_lvl;
  assign scanning = (st.tap == JTP_SH_DR) || (st.tap == JTP_SH_IR);
  assign exp_tap  = jtp_tap_next(st.tap, tms_smp);

  always_comb begin
    next_st        = st;
    next_st.tck_s  = {st.tck_s[1:0], tck_i};
    next_st.tms_s  = {st.tms_s[1:0], tms_i};
    next_st.tdi_s  = {st.tdi_s[1:0], tdi_i};
    next_st.trst_s = {st.trst_s[1:0], trst_n_i};
    if (st.tck_s[1] == st.tck_s[2]) begin
      next_st.tck_lvl = st.tck_s[2];
    end
    if (st.trst_s[1] == st.trst_s[2]) begin
      next_st.trst_lvl = st.trst_s[2];
    end
    // Pending byte leaves once the FIFO takes it
    if (st.pend && fifo_in_ready) begin
      next_st.pend = 1'b0;
    end
    if (!next_st.trst_lvl) begin
      // Test reset acts without any test clock edge
      next_st.tap      = JTP_TLR;
      next_st.ir       = JTP_IR_RST;
      next_st.tdo_oe_n = 1'b1;
    end else begin
      if (tck_rise) begin
        next_st.tap = exp_tap;
        case (st.tap)
          JTP_TLR: begin
            next_st.ir = JTP_IR_RST;
          end
          JTP_CAP_IR: begin
            next_st.ir_sh = JTP_IR_CAP;
          end
          JTP_SH_IR: begin
            next_st.ir_sh = {tdi_smp, st.ir_sh[JTP_IR_W-1:1]};
          end
          JTP_UPD_IR: begin
            next_st.ir = st.ir_sh;
          end
          JTP_CAP_DR: begin
            next_st.byp     = 1'b0;
            next_st.bit_cnt = '0;
            if (st.ir == JTP_IR_IDCODE) begin
              next_st.dr_sh = JTP_IDCODE;
            end else if (st.ir == JTP_IR_STREAM) begin
              // Report and clear the overflow flag
              next_st.dr_sh      = '0;
              next_st.dr_sh[1:0] = {st.ovf, st.pend};
              next_st.ovf        = 1'b0;
            end
          end
          JTP_SH_DR: begin
            next_st.byp   = tdi_smp;
            next_st.dr_sh = {tdi_smp, st.dr_sh[JTP_DR_W-1:1]};
            if (st.ir == JTP_IR_STREAM) begin
              next_st.word    = {tdi_smp, st.word[JTP_WORD_W-1:1]};
              next_st.bit_cnt = JTP_CNT_W'(st.bit_cnt + 1'b1);
              if (st.bit_cnt == JTP_CNT_LAST) begin
                // A full byte with the previous one still waiting is lost
                if (next_st.pend) begin
                  next_st.ovf = 1'b1;
                end else begin
                  next_st.pend      = 1'b1;
                  next_st.pend_word = {tdi_smp,
                                       st.word[JTP_WORD_W-1:1]};
                end
              end
            end
          end
          default: ;
        endcase
      end
      if (tck_fall) begin
        if (scanning) begin
          next_st.tdo_oe_n = 1'b0;
          if (st.tap == JTP_SH_IR) begin
            next_st.tdo = st.ir_sh[0];
          end else if ((st.ir == JTP_IR_IDCODE) ||
                       (st.ir == JTP_IR_STREAM)) begin
            next_st.tdo = st.dr_sh[0];
          end else begin
            next_st.tdo = st.byp;
          end
        end else if (clock_fail_flag_to_test_output_select_i) begin
          next_st.tdo_oe_n = 1'b0;
          next_st.tdo      = clk_fail_irq_i;
        end else begin
          next_st.tdo_oe_n = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st          <= '0;
      st.tap      <= JTP_TLR;
      st.ir       <= JTP_IR_RST;
      st.tdo_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  jtp_fifo #(
    .W (JTP_WORD_W),
    .D (JTP_FIFO_D)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (st.pend),
    .in_data_i   (st.pend_word),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (stream_valid_o),
    .out_data_o  (stream_data_o),
    .out_ready_i (stream_ready_i)
  );

  assign tdo_o             = st.tdo;
  assign tdo_oe_n_o        = st.tdo_oe_n;
  assign stream_overflow_o = st.ovf;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_rise_ok;
    tck_rise && next_st.trst_lvl;
  endsequence

  sequence s_fall_ok;
    tck_fall && next_st.trst_lvl;
  endsequence

  a_trst_forces_reset: assert property (
    !next_st.trst_lvl |=> (st.tap == JTP_TLR) && st.tdo_oe_n
                          && (st.ir == JTP_IR_RST))
    else $error("test reset did not reset the port");

  a_tms_steers_tap: assert property (
    s_rise_ok |=> st.tap == $past(exp_tap))
    else $error("controller did not follow mode select");

  a_tdi_into_ir: assert property (
    s_rise_ok ##0 (st.tap == JTP_SH_IR)
      |=> st.ir_sh[JTP_IR_W-1] == $past(tdi_smp))
    else $error("test data input not captured");

  a_tdo_on_fall: assert property (
    $changed(st.tdo) |-> $past(tck_fall))
    else $error("test data output changed off a falling edge");

  a_idle_holds: assert property (
    (!tck_rise && next_st.trst_lvl)
      |=> $stable(st.tap) && $stable(st.ir) && $stable(st.ir_sh))
    else $error("state changed without a test clock edge");

  a_oe_only_scan: assert property (
    s_fall_ok ##0 !scanning
      ##0 !clock_fail_flag_to_test_output_select_i |=> st.tdo_oe_n)
    else $error("data output driven outside a scan");

  a_flag_on_tdo: assert property (
    s_fall_ok ##0 !scanning ##0 clock_fail_flag_to_test_output_select_i
      |=> !st.tdo_oe_n && (st.tdo == $past(clk_fail_irq_i)))
    else $error("clock-fail flag not shown on data output");

  a_ir_update: assert property (
    s_rise_ok ##0 (st.tap == JTP_UPD_IR) |=> st.ir == $past(st.ir_sh))
    else $error("instruction not updated");

  a_rise_on_edge: assert property (
    (st.tck_s[2:1] == 2'b00) ##1 (st.tck_s[2:1] == 2'b01)
      ##1 (st.tck_s[2:1] == 2'b11) |-> tck_rise ##1 st.tck_lvl)
    else $error("test clock rise not detected");

  sequence s_byte_done;
    (st.tap == JTP_SH_DR) && (st.ir == JTP_IR_STREAM)
      && (st.bit_cnt == JTP_CNT_LAST);
  endsequence

  a_tlr_loads_ir: assert property (
    s_rise_ok ##0 (st.tap == JTP_TLR) |=> st.ir == JTP_IR_RST)
    else $error("instruction not reset in test logic reset");

  a_ir_capture: assert property (
    s_rise_ok ##0 (st.tap == JTP_CAP_IR) |=> st.ir_sh == JTP_IR_CAP)
    else $error("instruction capture pattern not loaded");

  a_id_capture: assert property (
    s_rise_ok ##0 (st.tap == JTP_CAP_DR) ##0 (st.ir == JTP_IR_IDCODE)
      |=> st.dr_sh == JTP_IDCODE)
    else $error("identification value not captured");

  a_dr_shift: assert property (
    s_rise_ok ##0 (st.tap == JTP_SH_DR)
      |=> st.dr_sh == {$past(tdi_smp), $past(st.dr_sh[JTP_DR_W-1:1])})
    else $error("data register did not shift in test data");

  a_scan_drives: assert property (
    s_fall_ok ##0 scanning |=> !st.tdo_oe_n)
    else $error("data output not driven during a scan");

  a_tdo_dr_bit: assert property (
    s_fall_ok ##0 (st.tap == JTP_SH_DR)
      ##0 ((st.ir == JTP_IR_IDCODE) || (st.ir == JTP_IR_STREAM))
      |=> st.tdo == $past(st.dr_sh[0]))
    else $error("data output not the register head bit");

  a_byte_pending: assert property (
    s_rise_ok ##0 s_byte_done ##0 (!st.pend || fifo_in_ready)
      |=> st.pend
          && (st.pend_word == $past({tdi_smp, st.word[JTP_WORD_W-1:1]})))
    else $error("completed byte not made pending");

  a_ovf_sets: assert property (
    s_rise_ok ##0 s_byte_done ##0 st.pend ##0 !fifo_in_ready |=> st.ovf)
    else $error("lost byte did not set overflow");

  a_ovf_clears: assert property (
    s_rise_ok ##0 (st.tap == JTP_CAP_DR) ##0 (st.ir == JTP_IR_STREAM)
      |=> !st.ovf && (st.dr_sh[1:0] == $past({st.ovf, st.pend})))
    else $error("overflow not reported and cleared on capture");

  a_ovf_sticky: assert property (
    st.ovf && !(tck_rise && (st.tap == JTP_CAP_DR)
                && (st.ir == JTP_IR_STREAM)) |=> st.ovf)
    else $error("overflow flag dropped without a capture");

  a_stream_hold: assert property (
    stream_valid_o && !stream_ready_i
      |=> stream_valid_o && $stable(stream_data_o))
    else $error("stream head changed before it was taken");

endmodule : jtp_tap

// ---- jtp_tester.sv ----
/*
  Model of the external test controller: drives the test clock, mode
  select and data input, and samples the data output on each rise.
  Assumes the bench resolves the output pad from its enable.
*/
`timescale 1ns/100ps
module jtp_tester (
  // Test port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One 64 ns period; the clock rests low between calls
  task automatic tick(input logic m, input logic d, output logic o);
    // Half a nanosecond keeps every pin change off a system clock rising edge
    #0.5;
    tms_o = m;
    tdi_o = d;
    #16;
    tck_o = 1'b1;
    o = tdo_i;
    #32;
    tck_o = 1'b0;
    #15.5;
  endtask : tick

  // Scan from idle and back; ir picks the instruction path
  task automatic scan(input logic ir, input int n,
                      input logic [63:0] din, output logic [63:0] dout);
    logic o;
    dout = '0;
    tick(1'b0, 1'b1, o);
    tick(1'b1, 1'b1, o);
    if (ir) begin
      tick(1'b1, 1'b1, o);
    end
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask : scan
endmodule : jtp_tester

// ---- jtp_tap_bench.sv ----
/*
  Self-checking bench of the test access port with a controller model.
  Assumes a 200 MHz system clock and the hand-over timing of the port.
*/
`timescale 1ns/100ps
module jtp_tap_bench;
  import jtp_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        trst_n    = 1'b1;
  logic        irq       = 1'b0;
  logic        sel       = 1'b0;
  logic        rdy       = 1'b0;
  logic        tck, tms, tdi, tdo, oe_n, tdo_pad, valid, ovf, o;
  logic [7:0]  data;
  logic [63:0] r;
  int          fail_count = 0;
  int          tests_run  = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;
  // Released pad shows the inverse of the last driven value
  assign tdo_pad = oe_n ? ~tdo : tdo;

  jtp_tap dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
    .tdo_oe_n_o(oe_n), .clk_fail_irq_i(irq),
    .clock_fail_flag_to_test_output_select_i(sel),
    .stream_data_o(data), .stream_valid_o(valid),
    .stream_ready_i(rdy), .stream_overflow_o(ovf));
  jtp_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo_pad));

  task automatic wclk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : wclk

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic t_idcode;
    chk(oe_n, 1'b1);
    tester.scan(1'b0, 32, 64'h0, r);
    chk(r[31:0], JTP_IDCODE);
    wclk(4);
    chk(oe_n, 1'b1);
    $display("test idcode done");
  endtask : t_idcode

  task automatic t_stream;
    int i;
    tester.scan(1'b1, 4, {60'h0, JTP_IR_STREAM}, r);
    chk(r[3:0], JTP_IR_CAP);
    wclk(300);
    tester.scan(1'b0, 48, 64'h6655_4433_2211, r);
    wclk(4);
    chk(ovf, 1'b1);
    for (int k = 1; k <= 5; k++) begin
      i = 0;
      while (valid !== 1'b1 && i < 50) begin
        wclk(1);
        i++;
      end
      chk(data, 8'(k * 8'h11));
      rdy = 1'b1;
      wclk(1);
      rdy = 1'b0;
    end
    wclk(2);
    chk(valid, 1'b0);
    tester.scan(1'b0, 2, 64'h0, r);
    chk(r[1:0], 2'h2);
    wclk(4);
    chk(ovf, 1'b0);
    $display("test stream done");
  endtask : t_stream

  task automatic t_flag;
    tester.tick(1'b0, 1'b1, o);
    wclk(4);
    chk(oe_n, 1'b1);
    sel = 1'b1;
    irq = 1'b1;
    tester.tick(1'b0, 1'b1, o);
    wclk(4);
    chk({oe_n, tdo}, 2'h1);
    irq = 1'b0;
    tester.tick(1'b0, 1'b1, o);
    wclk(4);
    chk({oe_n, tdo}, 2'h0);
    $display("test flag done");
  endtask : t_flag

  task automatic t_trst;
    tester.scan(1'b1, 4, {60'h0, JTP_IR_BYPASS}, r);
    tester.scan(1'b0, 2, 64'h1, r);
    chk(r[1:0], 2'h2);
    trst_n = 1'b0;
    wclk(6);
    chk(oe_n, 1'b1);
    sel    = 1'b0;
    trst_n = 1'b1;
    wclk(6);
    tester.scan(1'b0, 32, 64'h0, r);
    chk(r[31:0], JTP_IDCODE);
    $display("test trst done");
  endtask : t_trst

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    wclk(3);
    srst_i = 1'b0;
    wclk(6);
    t_idcode();
    t_stream();
    t_flag();
    t_trst();
    print_verdict();
  end
endmodule : jtp_tap_bench
